// [core/owdp_regs.svh]
// constants of the one-wire debug port: frame layout, calibration and break timing
`ifndef OWDP_REGS_SVH
`define OWDP_REGS_SVH

// ----------------------------------------
// character framing
// ----------------------------------------
`define OWDP_DATA_BITS 8
`define OWDP_LAST_IDX 4'h9
`define OWDP_STOP_IDX 4'h9

// ----------------------------------------
// baud detection and breaks
// ----------------------------------------
`define OWDP_CAL_LOW_BITS 8
`define OWDP_CAL_SHIFT 3
`define OWDP_MIN_DIV 512
`define OWDP_CAL_MAX_CNT 16'h1000
`define OWDP_BREAK_RX_BITS 9
`define OWDP_BREAK_TX_BITS 40
`define OWDP_BIT_W 10
`define OWDP_CNT_W 16

// ----------------------------------------
// buffering
// ----------------------------------------
`define OWDP_FIFO_DEPTH 32

`endif

// [core/owdp_pkg.sv]
// types of the one-wire debug port
package owdp_pkg;

    // link sequencer states, one-hot
    typedef enum logic [6:0] {
        LS_UNCAL = 7'h01, // waiting for calibration character
        LS_CAL = 7'h02, // measuring low period
        LS_READY = 7'h04, // calibrated and idle
        LS_RX = 7'h08, // receiving a character
        LS_TX = 7'h10, // sending a character
        LS_ERR = 7'h20, // sending break back
        LS_WAIT_HI = 7'h40 // waiting for the line to rise
    } link_state_e;

endpackage

// [core/owdp_sync2.sv]
// two flip-flop synchroniser for the debug line
`timescale 1ns/1ps
module owdp_sync2 (
    input wire logic i_clk, // system clock
    input wire logic i_d, // asynchronous level
    output logic o_q // synchronised level
);

    logic meta_reg; // first stage, read only by the second
    logic q_reg; // second stage

    // ----------------------------------------
    // no reset: the line must stay live during reset for strap capture
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        meta_reg <= i_d;
        q_reg <= meta_reg;
    end

    assign o_q = q_reg;

endmodule

// [core/owdp_fifo.sv]
// transmit byte fifo with valid and ready on both sides
`timescale 1ns/1ps
module owdp_fifo #(
    parameter int W = 8, // word width
    parameter int DEPTH = 32 // number of words
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // synchronous reset, active low
    input wire logic i_in_valid, // write request
    input wire logic [W-1:0] i_in_data, // write data
    output logic o_in_ready, // room for a word
    output logic o_out_valid, // a word is waiting
    output logic [W-1:0] o_out_data, // oldest word
    input wire logic i_out_ready // drain side takes the word
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH]; // storage
    logic [AW-1:0] wr_ptr_reg; // write pointer
    logic [AW-1:0] rd_ptr_reg; // read pointer
    logic [AW:0] count_reg; // words held
    logic [AW:0] count_next; // words held next
    logic in_ready_reg; // registered not-full
    logic push; // word written this cycle
    logic pop; // word read this cycle

    assign push = i_in_valid && in_ready_reg;
    assign pop = o_out_valid && i_out_ready;
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

    // ----------------------------------------
    // storage write
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // ----------------------------------------
    // pointers and fill level
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg <= count_next;
            in_ready_reg <= (count_next != (AW+1)'(DEPTH));
        end
    end

    assign o_in_ready = in_ready_reg;
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem[rd_ptr_reg];

endmodule

// [core/one_wire_debug_port_control.sv]
// one-wire debug port: serial link, baud detection, debug mode control
`timescale 1ns/1ps
`include "owdp_regs.svh"
module one_wire_debug_port_control #(
    parameter int FIFO_DEPTH = `OWDP_FIFO_DEPTH // transmit buffer depth
) (
    input wire logic i_clk, // system clock, 25 MHz
    input wire logic i_rst_n, // system reset, sync, active low
    input wire logic i_dbg_line, // debug line level from pad
    output logic o_dbg_out, // debug line output value, always low
    output logic o_dbg_oe_n, // low while pulling the line low
    input wire logic i_brk, // breakpoint instruction decoded
    input wire logic i_brk_en, // breakpoints enabled
    input wire logic i_mode_clr, // debug active bit written to zero
    input wire logic i_stop_mode, // device in deep-sleep stop
    input wire logic i_halt_mode, // device in halt
    input wire logic i_wdt_en, // watchdog enabled
    input wire logic i_tx_valid, // byte to send
    input wire logic [7:0] i_tx_data, // byte value
    output logic o_tx_ready, // transmit buffer has room
    output logic o_rx_valid, // received byte, one-cycle pulse
    output logic [7:0] o_rx_data, // received byte value
    output logic o_rx_error, // break, framing or collision pulse
    output logic o_calibrated, // baud rate measured
    output logic o_debug_active, // debug mode
    output logic o_fetch_stop, // halt instruction fetch
    output logic o_clk_keep, // keep clock running
    output logic o_periph_keep, // keep peripherals running
    output logic o_halt_exit, // leave halt
    output logic o_wdt_refresh, // refresh watchdog
    output logic o_sys_reset_req // request system reset
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    owdp_pkg::link_state_e state_reg; // link sequencer
    logic line_s; // synchronised line
    logic [`OWDP_CNT_W-1:0] cnt_reg; // bit timer
    logic [`OWDP_CNT_W-1:0] low_cnt_reg; // consecutive low cycles
    logic [`OWDP_BIT_W-1:0] bit_len_reg; // cycles per bit
    logic [3:0] idx_reg; // bit index in frame
    logic [9:0] tx_shift_reg; // outgoing frame
    logic [7:0] rx_shift_reg; // incoming bits
    logic [`OWDP_CNT_W-1:0] half_len; // half a bit
    logic [`OWDP_CNT_W-1:0] brk_rx_len; // nine bit times
    logic [`OWDP_CNT_W-1:0] brk_tx_len; // forty bit times
    logic [`OWDP_CNT_W-1:0] cal_len; // measured bit length
    logic brk_det; // host break seen
    logic fifo_valid; // byte waiting to send
    logic [7:0] fifo_data; // byte to send
    logic tx_take; // pop a byte into the shifter
    logic strap_reg; // line level in reset
    logic in_rst_reg; // previous cycle was in reset

    assign half_len = `OWDP_CNT_W'(bit_len_reg >> 1);
    assign brk_rx_len = `OWDP_CNT_W'(bit_len_reg * `OWDP_BREAK_RX_BITS);
    assign brk_tx_len = `OWDP_CNT_W'(bit_len_reg * `OWDP_BREAK_TX_BITS);
    assign cal_len = cnt_reg >> `OWDP_CAL_SHIFT;
    // a zero byte is exactly nine low bit times, so a break must outlast that
    assign brk_det = (low_cnt_reg > brk_rx_len);
    assign tx_take = (state_reg == owdp_pkg::LS_READY) && line_s && !brk_det && fifo_valid;

    // ----------------------------------------
    // line synchroniser and transmit buffer
    // ----------------------------------------
    owdp_sync2 u_sync (
        .i_clk(i_clk),
        .i_d(i_dbg_line),
        .o_q(line_s)
    );

    owdp_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_tx_valid),
        .i_in_data(i_tx_data),
        .o_in_ready(o_tx_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(tx_take)
    );

    // ----------------------------------------
    // consecutive low time on the line
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || line_s || state_reg != owdp_pkg::LS_READY && state_reg != owdp_pkg::LS_RX) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg != '1) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    // ----------------------------------------
    // link sequencer
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg <= owdp_pkg::LS_UNCAL;
            cnt_reg <= '0;
            bit_len_reg <= '0;
            idx_reg <= '0;
            tx_shift_reg <= '1;
            rx_shift_reg <= '0;
            o_rx_valid <= 1'b0;
            o_rx_data <= '0;
            o_rx_error <= 1'b0;
            o_dbg_oe_n <= 1'b1;
        end else begin
            o_rx_valid <= 1'b0;
            o_rx_error <= 1'b0;
            o_dbg_oe_n <= 1'b1;
            unique case (state_reg)
                owdp_pkg::LS_UNCAL: begin
                    // idle until the line is first seen low
                    if (!line_s) begin
                        state_reg <= owdp_pkg::LS_CAL;
                        cnt_reg <= `OWDP_CNT_W'(1);
                    end
                end
                owdp_pkg::LS_CAL: begin
                    // low span of the calibration byte is eight bit times
                    if (cnt_reg > `OWDP_CAL_MAX_CNT) begin
                        state_reg <= owdp_pkg::LS_WAIT_HI;
                    end else if (line_s) begin
                        bit_len_reg <= (cal_len == '0) ? `OWDP_BIT_W'(1) : `OWDP_BIT_W'(cal_len);
                        state_reg <= owdp_pkg::LS_READY;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                owdp_pkg::LS_READY: begin
                    if (brk_det) begin
                        state_reg <= owdp_pkg::LS_ERR;
                        cnt_reg <= brk_tx_len;
                        o_rx_error <= 1'b1;
                    end else if (!line_s) begin
                        state_reg <= owdp_pkg::LS_RX;
                        cnt_reg <= (half_len == '0) ? `OWDP_CNT_W'(1) : half_len;
                        idx_reg <= '0;
                    end else if (tx_take) begin
                        tx_shift_reg <= {1'b1, fifo_data, 1'b0};
                        state_reg <= owdp_pkg::LS_TX;
                        cnt_reg <= `OWDP_CNT_W'(bit_len_reg);
                        idx_reg <= '0;
                    end
                end
                owdp_pkg::LS_RX: begin
                    if (brk_det) begin
                        state_reg <= owdp_pkg::LS_ERR;
                        cnt_reg <= brk_tx_len;
                        o_rx_error <= 1'b1;
                    end else if (cnt_reg > `OWDP_CNT_W'(1)) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (idx_reg == '0 && line_s) begin
                        state_reg <= owdp_pkg::LS_READY;
                    end else if (idx_reg == `OWDP_STOP_IDX) begin
                        if (!line_s) begin
                            state_reg <= owdp_pkg::LS_ERR;
                            cnt_reg <= brk_tx_len;
                            o_rx_error <= 1'b1;
                        end else begin
                            state_reg <= owdp_pkg::LS_READY;
                            o_rx_valid <= 1'b1;
                            o_rx_data <= rx_shift_reg;
                        end
                    end else begin
                        if (idx_reg != '0) begin
                            rx_shift_reg <= {line_s, rx_shift_reg[7:1]};
                        end
                        idx_reg <= idx_reg + 1'b1;
                        cnt_reg <= `OWDP_CNT_W'(bit_len_reg);
                    end
                end
                owdp_pkg::LS_TX: begin
                    o_dbg_oe_n <= tx_shift_reg[0];
                    if (cnt_reg == half_len && tx_shift_reg[0] && !line_s) begin
                        state_reg <= owdp_pkg::LS_ERR;
                        cnt_reg <= brk_tx_len;
                        o_rx_error <= 1'b1;
                    end else if (cnt_reg > `OWDP_CNT_W'(1)) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (idx_reg == `OWDP_LAST_IDX) begin
                        state_reg <= owdp_pkg::LS_READY;
                        o_dbg_oe_n <= 1'b1;
                    end else begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                        idx_reg <= idx_reg + 1'b1;
                        cnt_reg <= `OWDP_CNT_W'(bit_len_reg);
                    end
                end
                owdp_pkg::LS_ERR: begin
                    // hold the line low for four character times
                    o_dbg_oe_n <= 1'b0;
                    if (cnt_reg > `OWDP_CNT_W'(1)) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else begin
                        // last low cycle still driven, released in wait state
                        state_reg <= owdp_pkg::LS_WAIT_HI;
                    end
                end
                owdp_pkg::LS_WAIT_HI: begin
                    // baud detector is cleared once the line is released
                    if (line_s) begin
                        state_reg <= owdp_pkg::LS_UNCAL;
                        bit_len_reg <= '0;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // strap capture in reset
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        in_rst_reg <= !i_rst_n;
        if (!i_rst_n) begin
            strap_reg <= line_s;
        end
    end

    // ----------------------------------------
    // debug mode flag
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_debug_active <= 1'b0;
        end else if (in_rst_reg) begin
            o_debug_active <= !strap_reg;
        end else if (i_brk && i_brk_en) begin
            o_debug_active <= 1'b1;
        end else if (i_mode_clr) begin
            o_debug_active <= 1'b0;
        end
    end

    // ----------------------------------------
    // system controls driven by debug mode, plus the stop-mode reset request and the calibrated flag
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_fetch_stop <= 1'b0;
            o_clk_keep <= 1'b0;
            o_periph_keep <= 1'b0;
            o_halt_exit <= 1'b0;
            o_wdt_refresh <= 1'b0;
            o_sys_reset_req <= 1'b0;
            o_calibrated <= 1'b0;
            o_dbg_out <= 1'b0;
        end else begin
            o_fetch_stop <= o_debug_active;
            o_clk_keep <= o_debug_active && !i_stop_mode;
            o_periph_keep <= o_debug_active && !i_stop_mode;
            o_halt_exit <= o_debug_active && i_halt_mode;
            o_wdt_refresh <= o_debug_active && i_wdt_en;
            o_sys_reset_req <= i_stop_mode && !line_s;
            o_calibrated <= (bit_len_reg != '0);
            o_dbg_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_tx_start;
        tx_take;
    endsequence

    sequence s_start_bit;
        !o_dbg_oe_n [*2];
    endsequence

    a_idle_release: assert property ((state_reg == owdp_pkg::LS_UNCAL) |=> o_dbg_oe_n)
        else $error("line driven while uncalibrated");
    a_half_duplex: assert property ((state_reg == owdp_pkg::LS_RX) |=> o_dbg_oe_n)
        else $error("line driven while receiving");
    a_start_bit: assert property (s_tx_start ##1 1'b1 |=> s_start_bit)
        else $error("start bit not driven low");
    a_fetch_stop: assert property (o_debug_active |=> o_fetch_stop)
        else $error("fetch not halted in debug mode");
    a_clk_keep: assert property (o_debug_active && !i_stop_mode |=> o_clk_keep && o_periph_keep)
        else $error("clock or peripherals stopped in debug");
    a_halt_exit: assert property (o_debug_active && i_halt_mode |=> o_halt_exit)
        else $error("halt not left in debug");
    a_wdt_keep: assert property (o_debug_active && i_wdt_en |=> o_wdt_refresh)
        else $error("watchdog not refreshed");
    a_brk_enter: assert property (i_brk && i_brk_en && !in_rst_reg |=> o_debug_active)
        else $error("breakpoint did not enter debug");
    a_strap_entry: assert property (in_rst_reg && !strap_reg |=> o_debug_active)
        else $error("strap did not enter debug");
    a_mode_clr: assert property (i_mode_clr && !i_brk && !in_rst_reg |=> !o_debug_active)
        else $error("debug mode not left on clear");
    a_brk_nop: assert property (i_brk && !i_brk_en && !o_debug_active && !in_rst_reg |=> !o_debug_active)
        else $error("disabled breakpoint entered debug");
    a_stop_reset: assert property (i_stop_mode && !line_s |=> o_sys_reset_req)
        else $error("no reset request from stop");
    a_err_break: assert property (o_rx_error |-> state_reg == owdp_pkg::LS_ERR ##1 !o_dbg_oe_n)
        else $error("error did not send break");

endmodule

// [testbench/host_port_model.sv]
// host serial port model on the far side of the debug line
`timescale 1ns/1ps
module host_port_model #(
    parameter int BIT_LEN = 16 // host bit time in system clocks
) (
    input wire logic i_clk, // system clock
    input wire logic i_line, // resolved debug line
    output logic o_oe_n // low while the host pulls the line
);
    logic busy = 1'b0; // host is sending, monitor ignores the line
    logic [8:0] fr_in; // sampled data and stop bit
    logic [7:0] rx_q[$]; // bytes received from the device
    int n_to = 0; // waits for a high line that ran out
    initial o_oe_n = 1'b1;

    // ----------------------------------------
    // send one frame, or hold the line low for n_low bit times
    // ----------------------------------------
    task automatic send(input logic [7:0] b, input logic stop_bit, input int n_low);
        logic [9:0] fr;
        fr = {stop_bit, b, 1'b0}; // start, lsb first, stop
        busy = 1'b1;
        // wait up to 4000 cycles for a high line before starting
        for (int k = 0; k < 4000 && i_line !== 1'b1; k++) @(negedge i_clk);
        if (i_line !== 1'b1) n_to++;
        if (n_low > 0) begin
            o_oe_n <= 1'b0;
            repeat (n_low * BIT_LEN) @(negedge i_clk);
        end else begin
            for (int i = 0; i < 10; i++) begin
                o_oe_n <= fr[i]; // only pulls low, else releases
                repeat (BIT_LEN) @(negedge i_clk);
            end
        end
        o_oe_n <= 1'b1;
        busy = 1'b0;
        repeat (2 * BIT_LEN) @(negedge i_clk);
    endtask

    // ----------------------------------------
    // receiver: mid-bit sampling, frames with a low stop are dropped
    // ----------------------------------------
    always @(negedge i_clk) begin
        // own release is still pending while o_oe_n shows low
        if (!busy && o_oe_n === 1'b1 && i_line === 1'b0) begin
            repeat (BIT_LEN / 2) @(negedge i_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_LEN) @(negedge i_clk);
                fr_in[i] = i_line;
            end
            if (fr_in[8] === 1'b1) rx_q.push_back(fr_in[7:0]);
            for (int k = 0; k < 4000 && i_line !== 1'b1; k++) @(negedge i_clk);
            if (i_line !== 1'b1) n_to++;
        end
    end
endmodule

// [testbench/tb.sv]
// self-checking bench of the one-wire debug port
`timescale 1ns/1ps
`include "owdp_regs.svh"
module tb;
    // ----------------------------------------
    // signals and counters
    // ----------------------------------------
    localparam int BL = 16; // host bit time in cycles
    localparam int FD = 32; // transmit buffer depth
    logic i_clk = 1'b0; // system clock
    logic i_rst_n = 1'b0; // synchronous reset
    logic strap_low = 1'b1; // bench pulls the line low
    logic host_oe_n, oe_n, dbg_out, line; // line drivers
    logic breakpoint_instruction = 0, brk_en = 0, mode_clr = 0, stop = 0, halt = 0, wdt_en = 0; // core side
    logic tx_valid = 0, tx_ready, rx_valid, rx_error, calibrated, active, sys_rst; // handshakes
    logic [7:0] tx_data = 8'h00, rx_data, seed = 8'h61; // data and lfsr state
    logic [4:0] ctl; // fetch, clock, peripheral, halt, watchdog
    logic exp_act = 1'b0; // expected debug mode
    logic [7:0] got_q[$], exp_q[$]; // received and expected bytes
    int n_checks = 0, n_mismatch = 0, n_err = 0, run = 0, last_run = 0, n_push, e0;

    always #20 i_clk = ~i_clk;
    assign line = (oe_n !== 1'b0) && (host_oe_n !== 1'b0) && !strap_low; // pull-up

    one_wire_debug_port_control #(.FIFO_DEPTH(FD)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_dbg_line(line), .o_dbg_out(dbg_out), .o_dbg_oe_n(oe_n), .i_brk(breakpoint_instruction), .i_brk_en(brk_en),
        .i_mode_clr(mode_clr), .i_stop_mode(stop), .i_halt_mode(halt), .i_wdt_en(wdt_en),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
        .o_rx_data(rx_data), .o_rx_error(rx_error), .o_calibrated(calibrated), .o_debug_active(active),
        .o_fetch_stop(ctl[4]), .o_clk_keep(ctl[3]), .o_periph_keep(ctl[2]), .o_halt_exit(ctl[1]),
        .o_wdt_refresh(ctl[0]), .o_sys_reset_req(sys_rst));
    host_port_model #(.BIT_LEN(BL)) host (.i_clk(i_clk), .i_line(line), .o_oe_n(host_oe_n));

    // ----------------------------------------
    // monitors: received bytes, error pulses, length of device pull-downs
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (rx_valid === 1'b1) got_q.push_back(rx_data);
        if (rx_error === 1'b1) n_err <= n_err + 1;
        if (oe_n === 1'b0) run <= run + 1;
        else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] ctl_exp(input logic a);
        return {3'h0, a, a & !stop, a & !stop, a & halt, a & wdt_en};
    endfunction
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic do_reset(input logic s);
        i_rst_n = 1'b0;
        strap_low = s;
        repeat (6) @(negedge i_clk);
        i_rst_n = 1'b1;
        strap_low = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask
    task automatic send_check(input logic [7:0] b);
        host.send(b, 1'b1, 0);
        chk_byte(got_q.size() > 0 ? got_q.pop_front() : 8'hxx, b, "received byte");
    endtask
    // line fault from the host: stop bit low or a held low level
    task automatic err_case(input logic stop_bit, input int n_low);
        e0 = n_err;
        host.send(8'h3c, stop_bit, n_low);
        for (int k = 0; k < 3000 && calibrated !== 1'b0; k++) @(negedge i_clk);
        chk_bit(calibrated, 1'b0, "detector reset");
        chk_byte(8'(n_err - e0), 8'h01, "error pulses");
        chk_byte(8'(last_run / BL), 8'(`OWDP_BREAK_TX_BITS), "break echo length");
        chk_bit(active, exp_act, "mode kept");
        host.send(8'h80, 1'b1, 0);
        send_check(8'hc3);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        @(negedge i_clk);
        do_reset(1'b1);
        chk_bit(active, 1'b1, "strap entry");
        chk_bit(ctl[4], 1'b1, "fetch halted");
        do_reset(1'b0);
        chk_bit(active, 1'b0, "reset exit");
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            breakpoint_instruction = seed[0];
            brk_en = seed[1];
            mode_clr = seed[2] & seed[3];
            stop = seed[4];
            halt = seed[5];
            wdt_en = seed[6];
            exp_act = (breakpoint_instruction & brk_en) ? 1'b1 : (mode_clr ? 1'b0 : exp_act);
            @(negedge i_clk);
            breakpoint_instruction = 1'b0;
            mode_clr = 1'b0;
            @(negedge i_clk);
            chk_bit(active, exp_act, "debug mode");
            chk_byte({3'h0, ctl}, ctl_exp(exp_act), "mode controls");
        end
        stop = 1'b0;
        host.send(8'h80, 1'b1, 0);
        chk_bit(calibrated, 1'b1, "calibrated");
        send_check(8'h00);
        send_check(8'hff);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            send_check(seed);
        end
        // fill the buffer while a host frame holds the link
        fork
            host.send(8'ha5, 1'b1, 0);
            begin
                repeat (12) @(negedge i_clk);
                n_push = 0;
                for (int k = 0; k < 40; k++) begin
                    seed = lfsr(seed);
                    tx_data = seed;
                    tx_valid = 1'b1;
                    if (tx_ready === 1'b1) exp_q.push_back(seed);
                    @(negedge i_clk);
                end
                tx_valid = 1'b0;
            end
        join
        chk_byte(got_q.size() > 0 ? got_q.pop_front() : 8'hxx, 8'ha5, "byte during fill");
        chk_byte(8'(exp_q.size()), 8'(FD), "buffer depth");
        for (int k = 0; k < 9000 && host.rx_q.size() < FD; k++) @(negedge i_clk);
        chk_byte(8'(host.rx_q.size()), 8'(FD), "bytes sent");
        while (exp_q.size() > 0 && host.rx_q.size() > 0) begin
            chk_byte(host.rx_q.pop_front(), exp_q.pop_front(), "sent byte");
        end
        chk_bit(tx_ready, 1'b1, "buffer drained");
        err_case(1'b0, 0);
        err_case(1'b1, 12);
        stop = 1'b1;
        strap_low = 1'b1;
        repeat (4) @(negedge i_clk);
        chk_bit(sys_rst, 1'b1, "reset request in stop");
        strap_low = 1'b0;
        stop = 1'b0;
        repeat (20) @(negedge i_clk);
        chk_bit(dbg_out, 1'b0, "line drive value");
        chk_byte(8'(host.n_to), 8'h00, "host line waits");
        summarize();
    end
endmodule
